// ---- lbm_host_model.sv ----
// host model issuing single-byte commands on the decoded command port
`timescale 1ns/10ps
module lbm_host_model (
   input  wire logic     clk_sys,   // system clock
   output logic          cmd_valid, // one-cycle command strobe
   output lbm_pkg::cmd_t cmd        // command fields
);
   import lbm_pkg::*;
   // idle bus at time zero
   initial begin
      cmd_valid = 1'b0;
      cmd       = '0;
   end
   // one command per call, launched and withdrawn on falling edges
   task automatic xfer(input logic g, input logic [ID_W-1:0] id, input logic wr,
                       input logic [7:0] addr, input logic [7:0] wdata);
      @(negedge clk_sys);
      cmd_valid = 1'b1;
      cmd       = '{bcast: g, dev_id: id, write: wr, addr: addr, wdata: wdata};
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      cmd       = ~cmd; // released fields show no stale value
   endtask
endmodule

// ---- lbm_pkg.sv ----
// package of constants and types for the led bypass power-up control block
// What this block does
// - load defaults before accepting any command
// - all twelve bypass switches closed after reset
// - switches stay closed until host enables dimming
// - supply and core undervoltage together restore defaults
// - open switch lights led, closed switch shunts
// - go-enable at 0x01 resets zero, gates switches
// - spread spectrum paused during serial transactions
// - external clock drives pwm and uart timing
// - spread spectrum only on charge-pump clock
// - fault output pulled low while any fault
// - clock output drives internal or passes external
// - external clock input optional, syncs device
// - device identifier taken from resistor pin level
// - resistor pin decodes to sixteen levels, four bits
// - missing external clock falls back to internal
package lbm_pkg;
   localparam int         N_SWITCH        = 12;
   localparam int         ID_W            = 4;
   localparam logic [7:0] ADDR_SWITCH_GO  = 8'h01;
   localparam logic [7:0] ADDR_CLOCK_CFG  = 8'h02;
   localparam int         GO_EN_BIT       = 0;
   localparam int         PWM_CLK_LSB     = 0;
   localparam logic [7:0] SWITCH_GO_RESET = 8'h00;
   localparam logic [7:0] CLOCK_CFG_RESET = 8'h00;
   // clock source / clock output selections
   localparam logic [1:0] PWM_CLK_INT      = 2'h0;
   localparam logic [1:0] PWM_CLK_INT_OUT  = 2'h1;
   localparam logic [1:0] PWM_CLK_EXT      = 2'h2;
   localparam logic [1:0] PWM_CLK_EXT_THRU = 2'h3;
   // timing
   localparam int         CLK_PERIOD_NS   = 10;
   localparam int         EXT_MISS_NS     = 4000;
   localparam int         EXT_MISS_CYC    = EXT_MISS_NS / CLK_PERIOD_NS;
   localparam int         ID_SETTLE_CYC   = 4;
   typedef struct packed {
      logic            bcast;
      logic [ID_W-1:0] dev_id;
      logic            write;
      logic [7:0]      addr;
      logic [7:0]      wdata;
   } cmd_t;
   typedef enum logic {st_init, st_run} ctl_state_t;
endpackage

// ---- lbm_power_ctl.sv ----
// led bypass switch power-up, clock source and id control
`timescale 1ns/10ps
module lbm_power_ctl #(
   parameter bit SPREAD_VARIANT = 1'b1 // charge pump spreading fitted
) (
   input  wire logic                          clk_sys,          // system clock
   input  wire logic                          resetn,           // power-on reset, active low
   input  wire logic                          input_supply_low, // supply below reset level
   input  wire logic                          core_supply_undervoltage, // core below uvlo
   input  wire logic [lbm_pkg::ID_W-1:0]      id_resistor_pin,  // decoded resistor level
   input  wire logic                          ext_clock_in,     // optional external clock
   input  wire logic                          int_osc_tick,     // internal oscillator tick
   input  wire logic                          int_osc_level,    // internal oscillator level
   input  wire logic                          uart_busy,        // serial transaction active
   input  wire logic                          cmd_valid,        // decoded command strobe
   input  wire lbm_pkg::cmd_t                 cmd,              // decoded command
   input  wire logic [lbm_pkg::N_SWITCH-1:0]  switch_open_req,  // pwm engine open request
   input  wire logic [4:0]                    fault_flags,      // fault conditions
   output logic                               cmd_ready,        // commands accepted
   output logic                               rd_valid,         // read data pulse
   output logic [7:0]                         rd_data,          // read data
   output logic [lbm_pkg::N_SWITCH-1:0]       bypass_close,     // 1 closes bypass switch
   output logic                               timing_tick,      // pwm and uart time base
   output logic                               cp_spread_en,     // charge pump spreading
   output logic                               clock_out_pin,    // clock output level
   output logic                               fault_n_pin_o,    // open-drain drive value
   output logic                               fault_n_pin_oe_n, // low while pulling low
   output logic [lbm_pkg::ID_W-1:0]           dev_id            // captured device id
);
   import lbm_pkg::*;

   logic [ID_W+2:0] sync_q;
   logic            ext_q, ext_q_d, ext_rise, ext_ok, use_ext, uvlo_reset, hit;
   logic [ID_W-1:0] id_q;
   logic [15:0]     miss_cnt, next_miss_cnt;
   logic            next_ext_q_d;
   ctl_state_t      state, next_state;
   logic [2:0]      settle, next_settle;
   logic [7:0]      switch_go, next_switch_go, clock_cfg, next_clock_cfg;
   logic [ID_W-1:0] next_dev_id;
   logic            next_rd_valid;
   logic [7:0]      next_rd_data;
   logic [N_SWITCH-1:0] next_bypass_close;
   logic            next_timing_tick, next_cp_spread_en, next_clock_out, next_fault_oe_n;

   level_sync #(.W(ID_W + 3)) level_sync_inst (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .d       ({ext_clock_in, input_supply_low, core_supply_undervoltage, id_resistor_pin}),
      .q       (sync_q)
   );

   // pin views and derived conditions
   assign ext_q      = sync_q[ID_W+2];
   assign uvlo_reset = sync_q[ID_W+1] & sync_q[ID_W];
   assign id_q       = sync_q[ID_W-1:0];
   assign ext_rise   = ext_q & ~ext_q_d;
   assign ext_ok     = miss_cnt < 16'(EXT_MISS_CYC);
   assign use_ext    = clock_cfg[PWM_CLK_LSB+1] & ext_ok;
   assign hit        = cmd.bcast | (cmd.dev_id == dev_id);
   assign cmd_ready  = (state == st_run);
   assign fault_n_pin_o = 1'b0;

   // external clock presence watchdog
   always_comb begin
      next_ext_q_d  = ext_q;
      next_miss_cnt = miss_cnt;
      if (ext_rise) begin
         next_miss_cnt = '0;
      end else if (ext_ok) begin
         next_miss_cnt = miss_cnt + 16'h0001;
      end
   end

   // state, registers, identifier capture and reads
   always_comb begin
      next_state     = state;
      next_settle    = settle;
      next_switch_go = switch_go;
      next_clock_cfg = clock_cfg;
      next_dev_id    = dev_id;
      next_rd_valid  = 1'b0;
      next_rd_data   = rd_data;
      if (uvlo_reset) begin
         next_state     = st_init;
         next_settle    = '0;
         next_switch_go = SWITCH_GO_RESET;
         next_clock_cfg = CLOCK_CFG_RESET;
      end else begin
         case (state)
            st_init: begin
               if (settle == 3'(ID_SETTLE_CYC)) begin
                  next_dev_id = id_q;
                  next_state  = st_run;
               end else begin
                  next_settle = settle + 3'h1;
               end
            end
            st_run: begin
               if (cmd_valid && hit && cmd.write) begin
                  if (cmd.addr == ADDR_SWITCH_GO) begin
                     next_switch_go = cmd.wdata;
                  end else if (cmd.addr == ADDR_CLOCK_CFG) begin
                     next_clock_cfg = cmd.wdata;
                  end
               end else if (cmd_valid && !cmd.bcast && cmd.dev_id == dev_id) begin
                  next_rd_valid = 1'b1;
                  if (cmd.addr == ADDR_SWITCH_GO) begin
                     next_rd_data = switch_go;
                  end else if (cmd.addr == ADDR_CLOCK_CFG) begin
                     next_rd_data = clock_cfg;
                  end else begin
                     next_rd_data = 8'h00;
                  end
               end
            end
            default: next_state = st_init;
         endcase
      end
   end

   // outputs toward switches, timing and pins
   always_comb begin
      // closed until go is set, then follow pwm
      next_bypass_close = switch_go[GO_EN_BIT] ? ~switch_open_req : {N_SWITCH{1'b1}};
      // unspread source selects time base
      next_timing_tick  = use_ext ? ext_rise : int_osc_tick;
      next_cp_spread_en = SPREAD_VARIANT & ~uart_busy;
      next_fault_oe_n   = ~(|fault_flags);
      case (clock_cfg[PWM_CLK_LSB +: 2])
         PWM_CLK_INT_OUT:  next_clock_out = int_osc_level;
         PWM_CLK_EXT_THRU: next_clock_out = ext_q;
         default:          next_clock_out = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ext_q_d          <= 1'b0;
         miss_cnt         <= 16'(EXT_MISS_CYC);
         state            <= st_init;
         settle           <= '0;
         switch_go        <= SWITCH_GO_RESET;
         clock_cfg        <= CLOCK_CFG_RESET;
         dev_id           <= '0;
         rd_valid         <= 1'b0;
         rd_data          <= 8'h00;
         bypass_close     <= {N_SWITCH{1'b1}};
         timing_tick      <= 1'b0;
         cp_spread_en     <= 1'b0;
         clock_out_pin    <= 1'b0;
         fault_n_pin_oe_n <= 1'b1;
      end else begin
         ext_q_d          <= next_ext_q_d;
         miss_cnt         <= next_miss_cnt;
         state            <= next_state;
         settle           <= next_settle;
         switch_go        <= next_switch_go;
         clock_cfg        <= next_clock_cfg;
         dev_id           <= next_dev_id;
         rd_valid         <= next_rd_valid;
         rd_data          <= next_rd_data;
         bypass_close     <= next_bypass_close;
         timing_tick      <= next_timing_tick;
         cp_spread_en     <= next_cp_spread_en;
         clock_out_pin    <= next_clock_out;
         fault_n_pin_oe_n <= next_fault_oe_n;
      end
   end

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   AST_NO_CMD_BEFORE_INIT: assert property (!cmd_ready && cmd_valid && !uvlo_reset
                                            |=> $stable(switch_go) && $stable(clock_cfg) && !rd_valid)
      else $error("command accepted before defaults loaded");
   AST_UVLO_DEFAULTS: assert property (uvlo_reset |=> switch_go == SWITCH_GO_RESET
                                       && clock_cfg == CLOCK_CFG_RESET && !cmd_ready)
      else $error("undervoltage did not restore defaults");
   AST_CLOSED_UNTIL_GO: assert property (!switch_go[GO_EN_BIT] |=> &bypass_close)
      else $error("switch opened while go disabled");
   AST_FOLLOW_PWM: assert property (switch_go[GO_EN_BIT] |=> bypass_close == ~$past(switch_open_req))
      else $error("switches do not follow pwm when enabled");
   AST_GO_WRITE: assert property (cmd_ready && cmd_valid && hit && cmd.write && cmd.addr == ADDR_SWITCH_GO
                                  && !uvlo_reset |=> switch_go == $past(cmd.wdata) ##1
                                  bypass_close == ($past(switch_go[GO_EN_BIT]) ? ~$past(switch_open_req)
                                                   : {N_SWITCH{1'b1}}))
      else $error("go register write not applied");
   AST_SPREAD_PAUSE: assert property (uart_busy |=> !cp_spread_en)
      else $error("spread spectrum active during transaction");
   AST_EXT_TIMING: assert property (use_ext |=> timing_tick == $past(ext_rise))
      else $error("time base not from external clock");
   AST_FALLBACK: assert property (!ext_ok |=> timing_tick == $past(int_osc_tick))
      else $error("no fallback to internal oscillator");
   AST_FAULT_PIN: assert property (|fault_flags |=> !fault_n_pin_oe_n)
      else $error("fault pin not pulled low");
   AST_CLK_THRU: assert property (clock_cfg[1:0] == PWM_CLK_EXT_THRU |=> clock_out_pin == $past(ext_q))
      else $error("clock output not passing external clock");
   AST_ID_CAPTURE: assert property ($rose(state == st_run) |-> dev_id == $past(id_q))
      else $error("device id not taken from resistor level");
   AST_READ_GO: assert property (cmd_ready && cmd_valid && !cmd.bcast && !cmd.write && cmd.dev_id == dev_id
                                 && cmd.addr == ADDR_SWITCH_GO && !uvlo_reset
                                 |=> rd_valid && rd_data == $past(switch_go))
      else $error("go register read not answered");
   AST_ID_FILTER: assert property (cmd_valid && !cmd.bcast && cmd.dev_id != dev_id && !uvlo_reset
                                   |=> $stable(switch_go) && $stable(clock_cfg) && !rd_valid)
      else $error("command for another device acted on");

   COV_GO_SET: cover property (cmd_ready && cmd_valid && cmd.write && cmd.addr == ADDR_SWITCH_GO);
   COV_EXT_USED: cover property (use_ext ##1 timing_tick);
   COV_FALLBACK: cover property (clock_cfg[PWM_CLK_LSB+1] && $fell(ext_ok));
   COV_UVLO: cover property (uvlo_reset ##1 !uvlo_reset);
   COV_READ: cover property (rd_valid);
endmodule

// ---- lbm_power_ctl_tb.sv ----
// self-checking bench for the led bypass power-up control block
`timescale 1ns/10ps
module lbm_power_ctl_tb;
   import lbm_pkg::*;
   typedef struct packed {
      logic [4:0]  fault_n_pin;
      logic        busy;
      logic [11:0] open_req;
      logic        exp_oe_n;
      logic        exp_spread;
   } row_t;
   localparam logic [3:0] ID_VAL = 4'ha;
   localparam row_t ROWS [4] = '{'{5'h00, 1'b0, 12'hfff, 1'b1, 1'b1}, '{5'h01, 1'b1, 12'h000, 1'b0, 1'b0},
                                 '{5'h10, 1'b0, 12'ha5a, 1'b0, 1'b1}, '{5'h00, 1'b1, 12'h001, 1'b1, 1'b0}};
   logic        clk_sys, resetn, in_low, core_uv, ext_clk, osc_tick, osc_lvl, uart_busy, cmd_valid;
   logic        cmd_ready, rd_valid, timing_tick, cp_spread_en, clock_out_pin, flt_o, flt_oe_n;
   logic [3:0]  id_pin, dev_id;
   logic [4:0]  fault_flags;
   logic [7:0]  rd_data;
   logic [11:0] open_req, bypass_close;
   cmd_t        cmd;
   int          miscompares = 0;
   int          n_checks = 0;
   int          n_tick = 0;
   int          tick_base = 0;
   lbm_host_model host_inst (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd(cmd));
   lbm_power_ctl lbm_power_ctl_inst (.clk_sys(clk_sys), .resetn(resetn), .input_supply_low(in_low),
      .core_supply_undervoltage(core_uv), .id_resistor_pin(id_pin), .ext_clock_in(ext_clk),
      .int_osc_tick(osc_tick), .int_osc_level(osc_lvl), .uart_busy(uart_busy), .cmd_valid(cmd_valid),
      .cmd(cmd), .switch_open_req(open_req), .fault_flags(fault_flags), .cmd_ready(cmd_ready),
      .rd_valid(rd_valid), .rd_data(rd_data), .bypass_close(bypass_close), .timing_tick(timing_tick),
      .cp_spread_en(cp_spread_en), .clock_out_pin(clock_out_pin), .fault_n_pin_o(flt_o),
      .fault_n_pin_oe_n(flt_oe_n), .dev_id(dev_id));
   // 100 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // time-base pulse counter
   always @(posedge clk_sys) if (timing_tick === 1'b1) n_tick++;
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic final_report();
      if (miscompares == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wait_ready();
      int i;
      for (i = 0; i < 30 && cmd_ready !== 1'b1; i++) @(negedge clk_sys);
      if (i == 30) begin
         miscompares++;
         final_report();
      end
   endtask
   task automatic wr(input logic g, input logic [3:0] id, input logic [7:0] addr, input logic [7:0] d);
      host_inst.xfer(g, id, 1'b1, addr, d);
      repeat (3) @(negedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
      int i;
      host_inst.xfer(1'b0, ID_VAL, 1'b0, addr, 8'h00);
      for (i = 0; i < 4 && rd_valid !== 1'b1; i++) @(negedge clk_sys);
      if (i == 4) begin
         miscompares++;
         final_report();
      end
      chk("rd_data", {8'h00, exp}, {8'h00, rd_data});
   endtask
   // main sequence
   initial begin
      {resetn, in_low, core_uv, ext_clk, osc_tick, osc_lvl, uart_busy} = '0;
      id_pin      = ID_VAL;
      fault_flags = 5'h00;
      open_req    = 12'hfff;
      repeat (12) @(negedge clk_sys);
      chk("bypass", 16'h0fff, {4'h0, bypass_close});
      chk("ready", 16'h0, {15'h0, cmd_ready});
      resetn = 1'b1;
      wr(1'b1, ID_VAL, ADDR_SWITCH_GO, 8'h01);
      wait_ready();
      chk("dev_id", {12'h0, ID_VAL}, {12'h0, dev_id});
      rd(ADDR_SWITCH_GO, SWITCH_GO_RESET);
      chk("bypass", 16'h0fff, {4'h0, bypass_close});
      wr(1'b0, ID_VAL, ADDR_SWITCH_GO, 8'h01);
      rd(ADDR_SWITCH_GO, 8'h01);
      // ordinary cases
      foreach (ROWS[r]) begin
         {fault_flags, uart_busy, open_req} = {ROWS[r].fault_n_pin, ROWS[r].busy, ROWS[r].open_req};
         repeat (4) @(negedge clk_sys);
         chk("bypass", {4'h0, ~ROWS[r].open_req}, {4'h0, bypass_close});
         chk("fault", {15'h0, ROWS[r].exp_oe_n}, {15'h0, flt_oe_n});
         chk("fault_o", 16'h0, {15'h0, flt_o});
         chk("spread", {15'h0, ROWS[r].exp_spread}, {15'h0, cp_spread_en});
      end
      {fault_flags, uart_busy, open_req} = {5'h00, 1'b0, 12'hfff};
      wr(1'b0, 4'h3, ADDR_SWITCH_GO, 8'h00);
      chk("bypass", 16'h0000, {4'h0, bypass_close});
      rd(8'h7f, 8'h00);
      wr(1'b1, 4'h3, ADDR_SWITCH_GO, 8'h00);
      chk("bypass", 16'h0fff, {4'h0, bypass_close});
      wr(1'b0, ID_VAL, ADDR_CLOCK_CFG, {6'h00, PWM_CLK_INT_OUT});
      osc_lvl = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk("clk_out", 16'h1, {15'h0, clock_out_pin});
      wr(1'b0, ID_VAL, ADDR_CLOCK_CFG, {6'h00, PWM_CLK_EXT_THRU});
      // external clock runs; internal ticks must be ignored meanwhile
      for (int k = 1; k <= 16; k++) begin
         ext_clk = ~ext_clk;
         osc_tick = 1'b1;
         @(negedge clk_sys);
         osc_tick = 1'b0;
         repeat (9) @(negedge clk_sys);
         chk("clk_out", {15'h0, ext_clk}, {15'h0, clock_out_pin});
         if (k == 4) tick_base = n_tick;
      end
      chk("ext_ticks", 16'd6, 16'(n_tick - tick_base));
      repeat (EXT_MISS_CYC + 50) @(negedge clk_sys);
      tick_base = n_tick;
      osc_tick = 1'b1;
      @(negedge clk_sys);
      osc_tick = 1'b0;
      repeat (4) @(negedge clk_sys);
      chk("int_ticks", 16'd1, 16'(n_tick - tick_base));
      // external source without pass-through keeps clock output low
      ext_clk = 1'b1;
      wr(1'b0, ID_VAL, ADDR_CLOCK_CFG, {6'h00, PWM_CLK_EXT});
      repeat (3) @(negedge clk_sys);
      chk("clk_out", 16'h0, {15'h0, clock_out_pin});
      // undervoltage needs both supply conditions
      wr(1'b0, ID_VAL, ADDR_SWITCH_GO, 8'h01);
      in_low = 1'b1;
      repeat (10) @(negedge clk_sys);
      chk("bypass", 16'h0000, {4'h0, bypass_close});
      core_uv = 1'b1;
      repeat (10) @(negedge clk_sys);
      chk("bypass", 16'h0fff, {4'h0, bypass_close});
      chk("ready", 16'h0, {15'h0, cmd_ready});
      {in_low, core_uv} = 2'b00;
      wait_ready();
      rd(ADDR_SWITCH_GO, SWITCH_GO_RESET);
      final_report();
   end
endmodule

// ---- level_sync.sv ----
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module level_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys, // system clock
   input  wire logic         resetn,  // async reset, active low
   input  wire logic [W-1:0] d,       // asynchronous inputs
   output logic      [W-1:0] q        // filtered synchronous level
);
   logic [W-1:0] s1, s2, s3;
   logic [W-1:0] next_q;

   // a bit changes only once stages two and three agree
   always_comb begin
      for (int i = 0; i < W; i++) begin
         next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         q  <= '0;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
         q  <= next_q;
      end
   end
endmodule
